// file: design/ccpcmp_pkg.sv
// Package for the compare-mode block: register map, field layout, mode codes.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
package ccpcmp_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COMPARE = 8'h04;
    localparam logic [7:0] OFF_ASSIGN = 8'h08;
    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLES = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_ADC_ENABLE = 8'h18;

    // Field positions and widths.
    localparam int MODE_W = 4;
    localparam int SEL_W = 2;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_TRIG_BIT = 1;
    localparam int IRQ_W = 2;

    // Reset values.
    localparam logic [3:0] CONTROL_RST = 4'h0;
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam logic [1:0] ASSIGN_RST = 2'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // Mode select codes used by compare.
    typedef enum logic [3:0] {
        CCPCMP_OFF = 4'b0000,
        CCPCMP_TOGGLE = 4'b0010,
        CCPCMP_SET_HIGH = 4'b1000,
        CCPCMP_SET_LOW = 4'b1001,
        CCPCMP_SOFT_IRQ = 4'b1010,
        CCPCMP_SPECIAL = 4'b1011
    } ccpcmp_mode_t;

    // Timer counts offered to the block, bundled.
    typedef struct packed {
        logic [15:0] t7;
        logic [15:0] t5;
        logic [15:0] t3;
        logic [15:0] t1;
    } ccpcmp_timers_t;

    // One-hot timer reset requests back to the timer resources.
    typedef struct packed {
        logic t7;
        logic t5;
        logic t3;
        logic t1;
    } ccpcmp_treset_t;

endpackage

// file: design/ccpcmp_match.sv
// Match detector: compares the compare value to the selected timer count.
// Assumes the timer count is on the same clock (timer or synchronized mode).
`timescale 1ns/1ps
module ccpcmp_match #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Comparison inputs.
    input wire logic i_active,
    input wire logic [WIDTH-1:0] i_value,
    input wire logic [WIDTH-1:0] i_count,
    // Single-cycle match event.
    output logic o_match
);

    logic eq;
    logic eq_prev_r;

    // Equality is qualified by the active flag so an off module never matches.
    assign eq = i_active && (i_value == i_count);

    // Remember last equality so a held match fires only once.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            eq_prev_r <= 1'b0;
        end else begin
            eq_prev_r <= eq;
        end
    end

    // Rising edge of equality is the event.
    assign o_match = eq && !eq_prev_r;

    property p_single_match;
        @(posedge i_clk) disable iff (i_srst)
        o_match |=> !o_match;
    endproperty
    a_single_match: assert property (p_single_match)
        else $error("match fired on two consecutive cycles");

endmodule

// file: design/ccpcmp_top.sv
// Compare-mode block of a capture/compare module with an AHB-Lite register slave.
// Assumes timer counts arrive on i_clk and timer resets are taken in one cycle.
`timescale 1ns/1ps
module ccpcmp_top #(
    parameter bit ENHANCED = 1'b0
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // AHB-Lite slave.
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Timer resources.
    input wire ccpcmp_pkg::ccpcmp_timers_t i_timers,
    output ccpcmp_pkg::ccpcmp_treset_t o_timer_reset,
    // Pin and port latch.
    input wire logic i_port_latch,
    input wire logic i_pin_dir_in,
    output logic o_pin_out,
    output logic o_pin_oe,
    // A/D start and interrupt.
    input wire logic i_adc_on,
    output logic o_adc_start,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [3:0] mode_r;
    logic [15:0] compare_r;
    logic [1:0] assign_r;
    logic [1:0] flags_r;
    logic [1:0] enables_r;
    logic latch_r;
    logic trig_r;
    logic [15:0] count;
    logic match;
    logic active;
    logic do_write;
    logic [7:0] wr_addr_r;
    logic wr_pend_r;
    logic [31:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one-cycle address phase, zero-wait data phase.

    // Function keeps the "is this a compare mode" decode in one place.
    function automatic logic is_compare(input logic [3:0] m);
        return (m == ccpcmp_pkg::CCPCMP_TOGGLE) || (m[3:2] == 2'b10);
    endfunction

    // A write is captured in the address phase and performed in the data phase.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (i_hready) begin
            wr_pend_r <= i_hsel && i_htrans[1] && i_hwrite;
            wr_addr_r <= i_haddr;
        end
    end

    assign do_write = wr_pend_r;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // Read data is registered from the address phase so it stands in the data phase.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (i_haddr == ccpcmp_pkg::OFF_CONTROL) begin
            rdata_nxt = {28'h000_0000, mode_r};
        end else if (i_haddr == ccpcmp_pkg::OFF_COMPARE) begin
            rdata_nxt = {16'h0000, compare_r};
        end else if (i_haddr == ccpcmp_pkg::OFF_ASSIGN) begin
            rdata_nxt = {30'h0000_0000, assign_r};
        end else if (i_haddr == ccpcmp_pkg::OFF_IRQ_FLAGS) begin
            rdata_nxt = {30'h0000_0000, flags_r};
        end else if (i_haddr == ccpcmp_pkg::OFF_IRQ_ENABLES) begin
            rdata_nxt = {30'h0000_0000, enables_r};
        end else if (i_haddr == ccpcmp_pkg::OFF_STATUS) begin
            rdata_nxt = {30'h0000_0000, trig_r, latch_r};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
            o_hrdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_r <= ccpcmp_pkg::CONTROL_RST;
            compare_r <= ccpcmp_pkg::COMPARE_RST;
            assign_r <= ccpcmp_pkg::ASSIGN_RST;
            enables_r <= ccpcmp_pkg::IRQ_RST;
        end else if (do_write) begin
            if (wr_addr_r == ccpcmp_pkg::OFF_CONTROL) begin
                mode_r <= i_hwdata[3:0];
            end else if (wr_addr_r == ccpcmp_pkg::OFF_COMPARE) begin
                compare_r <= i_hwdata[15:0];
            end else if (wr_addr_r == ccpcmp_pkg::OFF_ASSIGN) begin
                assign_r <= i_hwdata[1:0];
            end else if (wr_addr_r == ccpcmp_pkg::OFF_IRQ_ENABLES) begin
                enables_r <= i_hwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base selection and match detection.

    // Select 00 is timer one, 01 timer three, 10 timer five, 11 timer seven.
    always_comb begin
        case (assign_r)
            2'b00: count = i_timers.t1;
            2'b01: count = i_timers.t3;
            2'b10: count = i_timers.t5;
            default: count = i_timers.t7;
        endcase
    end

    assign active = is_compare(mode_r);

    ccpcmp_match #(
        .WIDTH(16)
    ) u_match (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_active(active),
        .i_value(compare_r),
        .i_count(count),
        .o_match(match)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare output latch and pin.

    // Clearing control forces the latch low; a match applies the mode action.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            latch_r <= 1'b0;
        end else if (do_write && wr_addr_r == ccpcmp_pkg::OFF_CONTROL
                     && i_hwdata[3:0] == ccpcmp_pkg::CCPCMP_OFF) begin
            latch_r <= 1'b0;
        end else if (match) begin
            case (mode_r)
                ccpcmp_pkg::CCPCMP_SET_HIGH: latch_r <= 1'b1;
                ccpcmp_pkg::CCPCMP_SET_LOW: latch_r <= 1'b0;
                ccpcmp_pkg::CCPCMP_TOGGLE: latch_r <= ~latch_r;
                default: latch_r <= latch_r;
            endcase
        end
    end

    // Pin-driving modes show the latch; other modes show the port latch.
    // The direction bit stays with the port; this block only reports it.
    assign o_pin_out = (mode_r == ccpcmp_pkg::CCPCMP_TOGGLE || mode_r[3:1] == 3'b100)
                       ? latch_r : i_port_latch;
    assign o_pin_oe = !i_pin_dir_in;

    ////////////////////////////////////////////////////////////////////////////
    // Special event trigger.

    // One-cycle pulse, registered in step with the latch and flag updates.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= match && (mode_r == ccpcmp_pkg::CCPCMP_SPECIAL);
        end
    end

    // Only the assigned timer is reset, so the compare value sets its period.
    always_comb begin
        o_timer_reset = '0;
        if (trig_r) begin
            case (assign_r)
                2'b00: o_timer_reset.t1 = 1'b1;
                2'b01: o_timer_reset.t3 = 1'b1;
                2'b10: o_timer_reset.t5 = 1'b1;
                default: o_timer_reset.t7 = 1'b1;
            endcase
        end
    end

    // Standard build never starts A/D; enhanced build only with converter on.
    assign o_adc_start = ENHANCED && trig_r && i_adc_on;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags: set wins over a write-one clear.

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flags_r <= ccpcmp_pkg::IRQ_RST;
        end else begin
            for (int i = 0; i < ccpcmp_pkg::IRQ_W; i++) begin
                if (do_write && wr_addr_r == ccpcmp_pkg::OFF_IRQ_FLAGS && i_hwdata[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
            if (match) begin
                flags_r[ccpcmp_pkg::IRQ_MATCH_BIT] <= 1'b1;
            end
            if (match && mode_r == ccpcmp_pkg::CCPCMP_SPECIAL) begin
                flags_r[ccpcmp_pkg::IRQ_TRIG_BIT] <= 1'b1;
            end
        end
    end

    // Interrupt reaches the processor only through the enable mask.
    assign o_irq = |(flags_r & enables_r);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_flag_with_action;
        @(posedge i_clk) disable iff (i_srst)
        match |=> flags_r[ccpcmp_pkg::IRQ_MATCH_BIT];
    endproperty
    a_flag_with_action: assert property (p_flag_with_action)
        else $error("match flag not set with pin action");

    property p_set_high;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_SET_HIGH && !do_write) |=> latch_r;
    endproperty
    a_set_high: assert property (p_set_high)
        else $error("latch not high after set-high match");

    property p_toggle;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_TOGGLE && !do_write)
            |=> latch_r != $past(latch_r);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("latch did not toggle on match");

    property p_soft_irq_pin;
        @(posedge i_clk) disable iff (i_srst)
        (mode_r == ccpcmp_pkg::CCPCMP_SOFT_IRQ) |-> o_pin_out == i_port_latch;
    endproperty
    a_soft_irq_pin: assert property (p_soft_irq_pin)
        else $error("pin touched in software interrupt mode");

    property p_clear_low;
        @(posedge i_clk) disable iff (i_srst)
        (do_write && wr_addr_r == ccpcmp_pkg::OFF_CONTROL && i_hwdata[3:0] == 4'h0)
            |=> !latch_r;
    endproperty
    a_clear_low: assert property (p_clear_low)
        else $error("latch not low after control cleared");

    property p_trigger_reset;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_SPECIAL) |=> (o_timer_reset != '0) ##1 !trig_r;
    endproperty
    a_trigger_reset: assert property (p_trigger_reset)
        else $error("special trigger did not reset a timer for one cycle");

    property p_no_adc;
        @(posedge i_clk) disable iff (i_srst)
        (!ENHANCED || !i_adc_on) |-> !o_adc_start;
    endproperty
    a_no_adc: assert property (p_no_adc)
        else $error("A/D start while not allowed");

    property p_off_quiet;
        @(posedge i_clk) disable iff (i_srst)
        !is_compare(mode_r) |-> !match;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("match while not in compare mode");

    property p_select;
        @(posedge i_clk) disable iff (i_srst)
        (assign_r == 2'b01) |-> count == i_timers.t3;
    endproperty
    a_select: assert property (p_select)
        else $error("wrong timer used as time base");

    property p_set_low;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_SET_LOW && !do_write) |=> !latch_r;
    endproperty
    a_set_low: assert property (p_set_low)
        else $error("latch not low after set-low match");

    property p_soft_irq_latch;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_SOFT_IRQ && !do_write) |=> $stable(latch_r);
    endproperty
    a_soft_irq_latch: assert property (p_soft_irq_latch)
        else $error("latch moved in software interrupt mode");

    property p_trigger_flag;
        @(posedge i_clk) disable iff (i_srst)
        (match && mode_r == ccpcmp_pkg::CCPCMP_SPECIAL) |=> flags_r[ccpcmp_pkg::IRQ_TRIG_BIT];
    endproperty
    a_trigger_flag: assert property (p_trigger_flag)
        else $error("special trigger did not raise its flag");

    property p_one_timer;
        @(posedge i_clk) disable iff (i_srst)
        trig_r |-> $onehot(o_timer_reset);
    endproperty
    a_one_timer: assert property (p_one_timer)
        else $error("special trigger reset not exactly one timer");

    // Only a software write-one may take the match flag down; hardware keeps it sticky.
    property p_flag_sticky;
        @(posedge i_clk) disable iff (i_srst)
        (flags_r[ccpcmp_pkg::IRQ_MATCH_BIT]
            && !(do_write && wr_addr_r == ccpcmp_pkg::OFF_IRQ_FLAGS
                 && i_hwdata[ccpcmp_pkg::IRQ_MATCH_BIT]))
            |=> flags_r[ccpcmp_pkg::IRQ_MATCH_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("match flag cleared without a software write");

endmodule

// file: tb/ccpcmp_timer_model.sv
// Behavioural model of the four timer resources that face the compare block.
// Assumes every timer runs on the block's own clock, in synchronized mode.
`timescale 1ns/1ps
module ccpcmp_timer_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Control from the bench.
    input wire logic i_run,
    input wire logic i_load,
    // Timer link.
    input wire ccpcmp_pkg::ccpcmp_treset_t i_treset,
    output ccpcmp_pkg::ccpcmp_timers_t o_timers
);
    ////////////////////////////////////////////////////////////////////////////
    // Counts move only on the system clock, so the comparator never sees a torn value.
    // A load parks each timer three counts short of its own compare point; the bases differ,
    // so only the selected timer can ever match.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_timers <= '0;
        end else if (i_load) begin
            o_timers <= {16'h0311, 16'h0211, 16'h0111, 16'h0011};
        end else begin
            o_timers.t1 <= i_treset.t1 ? 16'h0000 : o_timers.t1 + {15'h0000, i_run};
            o_timers.t3 <= i_treset.t3 ? 16'h0000 : o_timers.t3 + {15'h0000, i_run};
            o_timers.t5 <= i_treset.t5 ? 16'h0000 : o_timers.t5 + {15'h0000, i_run};
            o_timers.t7 <= i_treset.t7 ? 16'h0000 : o_timers.t7 + {15'h0000, i_run};
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the compare block: AHB-Lite register access, pin, irq and timers.
// Assumes the timer model in its own file and the block's package compiled first.
`timescale 1ns/1ps
module testbench;
    // One row: mode, timer select, port latch, enables, then pin, latch and flags expected.
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] sel;
        logic port;
        logic [1:0] en;
        logic pin;
        logic latch;
        logic [1:0] flg;
    } ccpcmp_row_t;
    localparam ccpcmp_row_t ROWS [6] = '{
        '{4'b0010, 2'h0, 1'b0, 2'h1, 1'b1, 1'b1, 2'h1},
        '{4'b1000, 2'h1, 1'b0, 2'h1, 1'b1, 1'b1, 2'h1},
        '{4'b1001, 2'h2, 1'b1, 2'h1, 1'b0, 1'b0, 2'h1},
        '{4'b1010, 2'h3, 1'b1, 2'h0, 1'b1, 1'b0, 2'h1},
        '{4'b1011, 2'h1, 1'b1, 2'h3, 1'b1, 1'b0, 2'h3},
        '{4'b0100, 2'h0, 1'b0, 2'h1, 1'b0, 1'b0, 2'h0}};
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_haddr = 8'h00;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [31:0] i_hwdata = 32'h0000_0000;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic i_port_latch = 1'b0;
    logic o_pin_out;
    logic o_pin_oe;
    logic o_adc_start;
    logic o_irq;
    logic run = 1'b0;
    logic load = 1'b0;
    logic pin_dir = 1'b0;
    ccpcmp_pkg::ccpcmp_timers_t tmr;
    ccpcmp_pkg::ccpcmp_treset_t trst;
    int err_count = 0;
    int n_checks = 0;
    int adc_n = 0;
    logic [31:0] q;
    logic [15:0] cmp;

    ////////////////////////////////////////////////////////////////////////////
    // The 50 ns clock and the instances; the pin direction is cleared so the result drives.
    always #25 i_clk = ~i_clk;
    ccpcmp_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(1'b1), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_timers(tmr), .o_timer_reset(trst), .i_port_latch(i_port_latch),
        .i_pin_dir_in(pin_dir), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_adc_on(1'b1),
        .o_adc_start(o_adc_start), .o_irq(o_irq));
    ccpcmp_timer_model partner (.i_clk(i_clk), .i_srst(i_srst), .i_run(run), .i_load(load),
        .i_treset(trst), .o_timers(tmr));

    // The converter is left enabled, so any start pulse would be counted here.
    always @(posedge i_clk) if (o_adc_start !== 1'b0) adc_n++;

    ////////////////////////////////////////////////////////////////////////////
    // Compares and reports one value.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; entered just after a rising edge, never waits a fixed time.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        i_haddr <= a;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        @(posedge i_clk);
        while (o_hreadyout !== 1'b1) @(posedge i_clk);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        @(posedge i_clk);
        while (o_hreadyout !== 1'b1) @(posedge i_clk);
        q = o_hrdata;
    endtask

    // Parks the timers three counts short, sets a mode, then counts up to one match.
    // The count then rests at equality unless a special trigger resets it, so a repeated action would show.
    task automatic fire(input logic [3:0] m);
        load <= 1'b1;
        @(posedge i_clk);
        load <= 1'b0;
        xfer(ccpcmp_pkg::OFF_CONTROL, 1'b1, {28'h0, m});
        run <= 1'b1;
        repeat (3) @(posedge i_clk);
        run <= 1'b0;
        repeat (20) @(posedge i_clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        final_report();
    end

    // Main sequence: the row loop, the set-low test, then a mid-run reset with its register sweep.
    initial begin
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        chk("pin_oe", 32'h1, {31'h0, o_pin_oe});
        foreach (ROWS[r]) begin
            cmp = {6'h00, ROWS[r].sel, 8'h14};
            xfer(ccpcmp_pkg::OFF_CONTROL, 1'b1, 32'h0000_0000);
            xfer(ccpcmp_pkg::OFF_IRQ_FLAGS, 1'b1, 32'h0000_0003);
            xfer(ccpcmp_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
            chk("latch_cleared", 32'h0, {31'h0, q[0]});
            xfer(ccpcmp_pkg::OFF_ASSIGN, 1'b1, {30'h0, ROWS[r].sel});
            xfer(ccpcmp_pkg::OFF_COMPARE, 1'b1, {16'h0000, cmp});
            xfer(ccpcmp_pkg::OFF_IRQ_ENABLES, 1'b1, {30'h0, ROWS[r].en});
            i_port_latch <= ROWS[r].port;
            fire(ROWS[r].mode);
            chk("pin_out", {31'h0, ROWS[r].pin}, {31'h0, o_pin_out});
            chk("irq", {31'h0, |(ROWS[r].flg & ROWS[r].en)}, {31'h0, o_irq});
            chk("timer", {16'h0, ROWS[r].mode == 4'b1011 ? 16'h0000 : cmp},
                {16'h0, tmr[ROWS[r].sel * 16 +: 16]});
            xfer(ccpcmp_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
            chk("latch", {31'h0, ROWS[r].latch}, {31'h0, q[0]});
            xfer(ccpcmp_pkg::OFF_IRQ_FLAGS, 1'b1, 32'h0000_0000);
            xfer(ccpcmp_pkg::OFF_IRQ_FLAGS, 1'b0, 32'h0000_0000);
            chk("flags", {30'h0, ROWS[r].flg}, q);
            $display("row %0d done", r);
        end
        // Set-low straight after set-high, control not cleared, so a no-op low would show.
        i_port_latch <= 1'b1;
        fire(4'b1000);
        chk("set_high_pin", 32'h1, {31'h0, o_pin_out});
        fire(4'b1001);
        chk("set_low_pin", 32'h0, {31'h0, o_pin_out});
        pin_dir <= 1'b1;
        @(posedge i_clk);
        chk("pin_oe_off", 32'h0, {31'h0, o_pin_oe});
        pin_dir <= 1'b0;
        $display("set-low test done");
        chk("adc_starts", 32'h0, adc_n);
        // Leave live state behind, then reset in mid-run and sweep the map.
        xfer(ccpcmp_pkg::OFF_COMPARE, 1'b1, 32'h0000_1234);
        xfer(8'h40, 1'b1, 32'h0000_00FF);
        i_port_latch <= 1'b1;
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        chk("irq_rst", 32'h0, {31'h0, o_irq});
        chk("pin_rst", 32'h1, {31'h0, o_pin_out});
        for (int a = 0; a <= 8'h40; a += 4) begin
            xfer(a[7:0], 1'b0, 32'h0000_0000);
            chk("reg_rst", 32'h0, q);
            chk("hresp", 32'h0, {31'h0, o_hresp});
        end
        $display("reset test done");
        final_report();
    end
endmodule
